// >>> core/pfc_pkg.sv
package pfc_pkg;
  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int PC_W = 12;
  localparam int IW_W = 16;
  localparam int DW = 8;
  localparam int DA_W = 9;
  localparam int STK_LEVELS = 8;
  localparam int STK_PTR_W = 3;
  localparam int STK_CNT_W = 4;
  localparam logic [STK_CNT_W-1:0] STK_FULL_CNT = 4'h8;
  localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
  localparam logic [DA_W-1:0] PCL_DADDR = 9'h006;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [AW-1:0] REG_PCL = 8'h00;
  localparam logic [AW-1:0] REG_CTRL = 8'h04;
  localparam logic [AW-1:0] REG_STATUS = 8'h08;
  localparam logic [AW-1:0] REG_ACC = 8'h0c;
  localparam logic [AW-1:0] REG_PC = 8'h10;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_INT_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Instruction fields
  // ---------------------------------------------------------------
  localparam int IR_DEST = 11;
  localparam int IR_SUB_LSB = 8;
  localparam logic [2:0] SUB_ADD = 3'h0;
  localparam logic [2:0] SUB_ADC = 3'h1;
  localparam logic [2:0] SUB_SUB = 3'h2;
  localparam logic [2:0] SUB_SBC = 3'h3;
  localparam logic [2:0] SUB_DAA = 3'h4;

  typedef enum logic [3:0] {
    OP_NOP = 4'b0000, OP_JMP = 4'b0001, OP_CALL = 4'b0010,
    OP_RET = 4'b0011, OP_MOVI = 4'b0100, OP_ARITH = 4'b0101,
    OP_LOGIC = 4'b0110, OP_ROT = 4'b0111, OP_INC = 4'b1000,
    OP_SKIP = 4'b1001, OP_MOVM = 4'b1010
  } pfc_op_t;

  typedef enum logic [1:0] {
    PH_T1 = 2'b00, PH_T2 = 2'b01, PH_T3 = 2'b10, PH_T4 = 2'b11
  } pfc_phase_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } pfc_flags_t;

  // Extended forms live at the top of the opcode space
  function automatic logic pfc_is_ext(input logic [3:0] op);
    pfc_is_ext = (op[3:2] == 2'b11);
  endfunction

  function automatic logic [3:0] pfc_base_op(input logic [3:0] op);
    pfc_base_op = pfc_is_ext(op) ? {1'b0, op[2:0]} : op;
  endfunction

  function automatic logic pfc_reg_mapped(input logic [AW-1:0] a);
    pfc_reg_mapped = (a == REG_PCL) || (a == REG_CTRL) ||
      (a == REG_STATUS) || (a == REG_ACC) || (a == REG_PC);
  endfunction
endpackage

// >>> core/pfc_alu.sv
`timescale 1ns/1ps
module pfc_alu import pfc_pkg::*; (
  // Operation
  input wire logic [3:0] op,
  input wire logic [2:0] sub,
  // Operands
  input wire logic [DW-1:0] acc,
  input wire logic [DW-1:0] opnd,
  input wire pfc_flags_t flags_i,
  // Results
  output logic [DW-1:0] res,
  output pfc_flags_t flags_o,
  output logic skip
);
  logic [DW:0] sum;
  logic [4:0] half;
  logic [DW-1:0] b;
  logic cin;
  logic [DW:0] t;
  logic lo_adj;
  logic hi_adj;

  // ---------------------------------------------------------------
  // Shared adder
  // ---------------------------------------------------------------
  always_comb begin
    b = sub[1] ? ~opnd : opnd;
    case (sub)
      SUB_ADC: cin = flags_i.c;
      SUB_SUB: cin = 1'b1;
      SUB_SBC: cin = flags_i.c;
      default: cin = 1'b0;
    endcase
    sum = {1'b0, acc} + {1'b0, b} + {8'h00, cin};
    half = {1'b0, acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    lo_adj = (acc[3:0] > 4'h9) || flags_i.ac;
    t = {1'b0, acc} + (lo_adj ? 9'h006 : 9'h000);
    hi_adj = (t[7:4] > 4'h9) || flags_i.c || t[8];
  end

  // ---------------------------------------------------------------
  // Operation select
  // ---------------------------------------------------------------
  always_comb begin
    res = acc;
    flags_o = flags_i;
    skip = 1'b0;
    case (op)
      OP_MOVI: res = opnd;
      OP_MOVM: res = acc;
      OP_ARITH: begin
        if (sub == SUB_DAA) begin
          res = 8'(t + (hi_adj ? 9'h060 : 9'h000));
          flags_o.c = hi_adj;
        end else begin
          res = sum[7:0];
          flags_o.c = sum[8];
          flags_o.ac = half[4];
          flags_o.ov = (acc[7] == b[7]) && (sum[7] != acc[7]);
        end
        flags_o.z = (res == 8'h00);
      end
      OP_LOGIC: begin
        case (sub[1:0])
          2'h0: res = acc & opnd;
          2'h1: res = acc | opnd;
          2'h2: res = acc ^ opnd;
          default: res = ~opnd;
        endcase
        flags_o.z = (res == 8'h00);
      end
      OP_ROT: begin
        case (sub[1:0])
          2'h0: res = {opnd[0], opnd[7:1]};
          2'h1: res = {flags_i.c, opnd[7:1]};
          2'h2: res = {opnd[6:0], opnd[7]};
          default: res = {opnd[6:0], flags_i.c};
        endcase
        if (sub[0]) begin
          flags_o.c = sub[1] ? opnd[7] : opnd[0];
        end
      end
      OP_INC: begin
        res = sub[0] ? opnd - 8'h01 : opnd + 8'h01;
        flags_o.z = (res == 8'h00);
      end
      OP_SKIP: begin
        case (sub[1:0])
          2'h0: res = opnd;
          2'h1: res = opnd;
          2'h2: res = opnd + 8'h01;
          default: res = opnd - 8'h01;
        endcase
        skip = (sub[1:0] == 2'h1) ? (res != 8'h00) : (res == 8'h00);
      end
      default: res = acc;
    endcase
  end
endmodule

// >>> core/pfc_stack.sv
`timescale 1ns/1ps
module pfc_stack import pfc_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Push and pop
  input wire logic push,
  input wire logic pop,
  input wire logic [PC_W-1:0] din,
  // Top and level
  output logic [PC_W-1:0] dout,
  output logic full,
  output logic [STK_CNT_W-1:0] depth
);
  logic [PC_W-1:0] mem_q [STK_LEVELS];
  logic [STK_PTR_W-1:0] sp_q;
  logic [STK_CNT_W-1:0] cnt_q;

  assign dout = mem_q[sp_q - 3'h1];
  assign full = (cnt_q == STK_FULL_CNT);
  assign depth = cnt_q;

  // ---------------------------------------------------------------
  // Ring of levels, overflow overwrites the oldest
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[sp_q] <= din;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_q <= 3'h0;
      cnt_q <= 4'h0;
    end else if (push) begin
      sp_q <= sp_q + 3'h1;
      cnt_q <= full ? cnt_q : cnt_q + 4'h1;
    end else if (pop && cnt_q != 4'h0) begin
      sp_q <= sp_q - 3'h1;
      cnt_q <= cnt_q - 4'h1;
    end
  end

  a_push_full: assert property (@(posedge aclk) disable iff (!aresetn)
    push && full |=> full && dout == $past(din))
    else $error("push on full stack lost level or data");
endmodule

// >>> core/pfc_core.sv
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - Core runs on aclk, whichever internal oscillator is selected.
// - Four phases INSTRUCTION_PHASES make one instruction cycle.
// - Counter advances at T1 while the next word is fetched.
// - Fetch of next word overlaps execution of current one.
// - Standard one cycle, extended two, branches one extra.
// - Jump or call: one cycle for target, one dummy for branch.
// - Counter steps by one per instruction unless control moves.
// - Counter is 12 bits; software sees low byte at PCL, all 12 bits at REG_PC.
// - Jump, call, interrupt and reset load target straight in.
// - Taken skip drops the prefetched word; a dummy cycle follows.
// - Low byte write jumps within current 256 page, adds dummy.
// - Eight-level stack of counter values; contents hidden, depth and full readable in REG_STATUS.
// - Call and interrupt acknowledge push; returns pop.
// - Reset puts the stack pointer at the top.
// - Full stack holds back acknowledge until a return frees level.
// - Call on full stack proceeds and loses the oldest entry.
// - 8-bit ALU with accumulator as main data path.
// - ALU result goes to chosen target; status flags update.
// - Add/sub, daa, logic, rotates, inc/dec, skip decisions.
// - Counter addresses 4K words of 16-bit program memory.
// - Reset loads counter with zero and starts there.
module pfc_core import pfc_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Program memory
  output logic [PC_W-1:0] pm_addr,
  input wire logic [IW_W-1:0] pm_rdata,
  // Data memory
  output logic [DA_W-1:0] dm_addr,
  input wire logic [DW-1:0] dm_rdata,
  output logic [DW-1:0] dm_wdata,
  output logic dm_we,
  // Interrupt logic
  input wire logic int_req,
  input wire logic [PC_W-1:0] int_vector,
  output logic int_ack
);
  pfc_phase_t phase_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pm_addr_q;
  logic [IW_W-1:0] ir_q;
  logic [PC_W-1:0] ir_pc_q;
  logic ir_vld_q;
  logic stall_q;
  logic [DW-1:0] acc_q;
  pfc_flags_t flags_q;
  logic [1:0] ctrl_q;
  logic pcl_pend_q;
  logic [DW-1:0] pcl_val_q;
  logic [DA_W-1:0] dm_addr_q;
  logic [DW-1:0] dm_wdata_q;
  logic dm_we_q;
  logic int_ack_q;
  logic aw_vld_q;
  logic [AW-1:0] aw_addr_q;
  logic w_vld_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic run;
  logic t1;
  logic t2;
  logic t4;
  logic [3:0] bop;
  logic ext;
  logic take_int;
  logic ext_start;
  logic exec;
  logic [DW-1:0] opnd;
  logic [DW-1:0] alu_res;
  pfc_flags_t alu_flags;
  logic alu_skip;
  logic alu_class;
  logic to_mem;
  logic wr_mem;
  logic wr_pcl;
  logic skip_hit;
  logic redirect;
  logic [PC_W-1:0] target;
  logic [PC_W-1:0] ret_addr;
  logic stk_push;
  logic stk_pop;
  logic [PC_W-1:0] stk_top;
  logic stk_full;
  logic [STK_CNT_W-1:0] stk_depth;
  logic wr_go;

  // ---------------------------------------------------------------
  // Phase sequencer
  // ---------------------------------------------------------------
  assign run = ctrl_q[CTRL_RUN];
  assign t1 = run && (phase_q == PH_T1);
  assign t2 = run && (phase_q == PH_T2);
  assign t4 = run && (phase_q == PH_T4);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= PH_T1;
    end else if (run) begin
      case (phase_q)
        PH_T1: phase_q <= PH_T2;
        PH_T2: phase_q <= PH_T3;
        PH_T3: phase_q <= PH_T4;
        PH_T4: phase_q <= PH_T1;
        default: phase_q <= PH_T1;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign bop = pfc_base_op(ir_q[15:12]);
  assign ext = pfc_is_ext(ir_q[15:12]);
  assign take_int = ctrl_q[CTRL_INT_EN] && int_req && !stk_full &&
    !stall_q;
  assign ext_start = ir_vld_q && ext && !stall_q && !take_int;
  assign exec = ir_vld_q && !take_int && !ext_start;
  assign opnd = (bop == OP_MOVI) ? ir_q[7:0] :
    (dm_addr_q == PCL_DADDR) ? pc_q[7:0] : dm_rdata;
  assign alu_class = (bop == OP_ARITH) || (bop == OP_LOGIC) ||
    (bop == OP_ROT) || (bop == OP_INC);
  assign to_mem = ir_q[IR_DEST] || (bop == OP_MOVM);
  assign wr_mem = exec && to_mem && (alu_class || (bop == OP_MOVM) ||
    (bop == OP_SKIP && ir_q[9]));
  assign wr_pcl = wr_mem && (dm_addr_q == PCL_DADDR);
  assign skip_hit = exec && (bop == OP_SKIP) && alu_skip;
  assign ret_addr = ir_vld_q ? ir_pc_q : pm_addr_q;

  pfc_alu u_alu (
    .op(bop),
    .sub(ir_q[IR_SUB_LSB +: 3]),
    .acc(acc_q),
    .opnd(opnd),
    .flags_i(flags_q),
    .res(alu_res),
    .flags_o(alu_flags),
    .skip(alu_skip)
  );

  // ---------------------------------------------------------------
  // Redirect select
  // ---------------------------------------------------------------
  always_comb begin
    redirect = 1'b1;
    target = pc_q;
    if (take_int) begin
      target = int_vector;
    end else if (exec && (bop == OP_JMP || bop == OP_CALL)) begin
      target = ir_q[11:0];
    end else if (exec && bop == OP_RET) begin
      target = stk_top;
    end else if (wr_pcl) begin
      target = {pc_q[11:8], alu_res};
    end else if (pcl_pend_q && !ext_start && !stall_q) begin
      target = {pc_q[11:8], pcl_val_q};
    end else begin
      redirect = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Program counter and fetch
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= RESET_VECTOR;
      pm_addr_q <= RESET_VECTOR;
    end else if (t1 && !stall_q) begin
      pm_addr_q <= pc_q;
      pc_q <= pc_q + 12'h001;
    end else if (t4 && redirect) begin
      pc_q <= target;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_q <= 16'h0000;
      ir_pc_q <= RESET_VECTOR;
      ir_vld_q <= 1'b0;
      stall_q <= 1'b0;
    end else if (t4) begin
      stall_q <= ext_start;
      if (!ext_start) begin
        ir_q <= pm_rdata;
        ir_pc_q <= pm_addr_q;
        ir_vld_q <= !redirect && !skip_hit;
      end
    end
  end

  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 8'h00;
      flags_q <= '0;
    end else if (t4 && exec) begin
      if (!to_mem && (alu_class || bop == OP_MOVI ||
          (bop == OP_SKIP && ir_q[9]))) begin
        acc_q <= alu_res;
      end
      if (alu_class) begin
        flags_q <= alu_flags;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dm_addr_q <= 9'h000;
    end else if (t2) begin
      dm_addr_q <= {ext, ir_q[7:0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dm_we_q <= 1'b0;
      dm_wdata_q <= 8'h00;
    end else begin
      dm_we_q <= t4 && wr_mem && !wr_pcl;
      if (t4 && wr_mem) begin
        dm_wdata_q <= alu_res;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_ack_q <= 1'b0;
    end else begin
      int_ack_q <= t4 && take_int;
    end
  end

  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  assign stk_push = t4 && (take_int || (exec && bop == OP_CALL));
  assign stk_pop = t4 && exec && (bop == OP_RET);

  pfc_stack u_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(stk_push),
    .pop(stk_pop),
    .din(take_int ? ret_addr : pm_addr_q),
    .dout(stk_top),
    .full(stk_full),
    .depth(stk_depth)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite write
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_vld_q && !bvalid_q;
  assign s_axi_wready = !w_vld_q && !bvalid_q;
  assign wr_go = aw_vld_q && w_vld_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_vld_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_vld_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (wr_go) begin
        aw_vld_q <= 1'b0;
        w_vld_q <= 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_vld_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_vld_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= pfc_reg_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_go && aw_addr_q == REG_CTRL && w_strb_q[0]) begin
      ctrl_q <= w_data_q[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcl_pend_q <= 1'b0;
      pcl_val_q <= 8'h00;
    end else begin
      if (t4 && redirect && !take_int && !wr_pcl &&
          !(exec && (bop == OP_JMP || bop == OP_CALL || bop == OP_RET))) begin
        pcl_pend_q <= 1'b0;
      end
      if (wr_go && aw_addr_q == REG_PCL && w_strb_q[0]) begin
        pcl_pend_q <= 1'b1;
        pcl_val_q <= w_data_q[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= pfc_reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_PCL: rdata_q <= {24'h000000, pc_q[7:0]};
        REG_CTRL: rdata_q <= {30'h00000000, ctrl_q};
        REG_STATUS: rdata_q <= {23'h000000, stk_full, stk_depth, flags_q};
        REG_ACC: rdata_q <= {24'h000000, acc_q};
        REG_PC: rdata_q <= {20'h00000, pc_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pm_addr = pm_addr_q;
  assign dm_addr = dm_addr_q;
  assign dm_wdata = dm_wdata_q;
  assign dm_we = dm_we_q;
  assign int_ack = int_ack_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_phase_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    t1 ##1 run [*3] |-> phase_q == PH_T4)
    else $error("phase sequence is not four steps");
  a_pc_step: assert property (@(posedge aclk) disable iff (!aresetn)
    t1 && !stall_q |=> pc_q == $past(pc_q) + 12'h001)
    else $error("counter did not step at T1");
  a_reset_start: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> pc_q == 12'h000 && stk_depth == 4'h0)
    else $error("reset state wrong");
  a_jump_target: assert property (@(posedge aclk) disable iff (!aresetn)
    t4 && exec && bop == OP_JMP && !take_int |=>
    pc_q == $past(ir_q[11:0]) ##1 pm_addr_q == $past(pc_q))
    else $error("jump target not loaded and fetched");
  a_dummy_after: assert property (@(posedge aclk) disable iff (!aresetn)
    t4 && (redirect || skip_hit) && !ext_start |=> !ir_vld_q)
    else $error("prefetched word not discarded");
  a_pcl_page: assert property (@(posedge aclk) disable iff (!aresetn)
    t4 && wr_pcl |=> pc_q == {$past(pc_q[11:8]), $past(alu_res)})
    else $error("low byte jump left page");
  a_ack_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    int_ack |-> !$past(stk_full) && pc_q == $past(int_vector))
    else $error("acknowledge with full stack or wrong vector");
  a_ext_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    t4 && ext_start |=> stall_q ##3 t4 && exec)
    else $error("extended op did not take two cycles");
endmodule

// >>> bench/test_pfc_core.sv
`timescale 1ns/1ps
module test_pfc_core import pfc_pkg::*;;
  // -----------------------------------------
  // Stimulus and design
  // -----------------------------------------
  logic aclk = 0, aresetn = 0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, dm_we, int_ack;
  logic [PC_W-1:0] pm_addr, tgt, ivec = '0;
  logic [IW_W-1:0] pm [4096];
  logic [DA_W-1:0] dm_addr;
  logic [DW-1:0] dm_rdata = '0, dm_wdata;
  logic int_req = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic aq[$];
  logic [16:0] dq[$];
  logic [7:0] imm, da;
  int mismatches = 0, comparisons = 0;

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    dm_rdata <= 8'($urandom);
  end

  pfc_core uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pm_addr(pm_addr), .pm_rdata(pm[pm_addr]),
    .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata),
    .dm_we(dm_we), .int_req(int_req), .int_vector(ivec), .int_ack(int_ack));

  // -----------------------------------------
  // Checking
  // -----------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic lim(input int n);
    if (n >= 60) begin
      mismatches++;
      conclude();
    end
  endtask

  always @(negedge aclk) begin
    if (rvalid) chk({rresp, rdata}, rq.pop_front());
    if (bvalid) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (dm_we)
      chk({17'h0, dm_addr, dm_wdata}, {17'h0, dq.pop_front()});
    if (int_ack) begin
      chk(34'h1, {33'h0, aq.size() != 0});
      if (aq.size() != 0) void'(aq.pop_front());
    end
  end

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    logic pa, pw, ah, wh;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    pa = 1;
    pw = 1;
    while ((pa || pw) && n < 60) begin
      @(negedge aclk);
      ah = pa && awready;
      wh = pw && wready;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      pa = pa && !ah;
      pw = pw && !wh;
      n++;
    end
    do begin
      @(negedge aclk);
      n++;
    end while (!bvalid && n < 60);
    @(posedge aclk);
    lim(n);
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!arready && n < 60);
    @(posedge aclk);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
    end while (!rvalid && n < 60);
    @(posedge aclk);
    lim(n);
  endtask

  task automatic wait_pc(input logic [PC_W-1:0] a);
    int n;
    n = 0;
    while (pm_addr !== a && n < 300) begin
      @(negedge aclk);
      n++;
    end
    chk({22'h0, pm_addr}, {22'h0, a});
    if (n >= 300) conclude();
  endtask

  // -----------------------------------------
  // Scenarios
  // -----------------------------------------
  initial begin
    for (int i = 0; i < 4096; i++) pm[i] = {4'h1, i[11:0]};
    for (int i = 0; i < 9; i++) pm[i*16] = {4'h2, 12'(i*16+16)};
    void'($urandom(51940));
    ivec = {4'h5, 2'h0, 6'($urandom)};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_STATUS, 34'h0);
    rd(8'h14, {RESP_SLVERR, 32'h0});
    wr(8'h18, $urandom, RESP_SLVERR);
    wr(REG_ACC, $urandom, RESP_OKAY);
    rd(REG_ACC, 34'h0);
    wait_pc(12'h090);
    rd(REG_STATUS, 34'h180);
    @(posedge aclk);
    int_req <= 1'b1;
    wr(REG_CTRL, 32'h3, RESP_OKAY);
    repeat (40) @(posedge aclk);
    aq.push_back(1'b1);
    pm[12'h090] = 16'h3000;
    wait_pc(ivec);
    @(posedge aclk);
    int_req <= 1'b0;
    tgt = {ivec[11:8], 1'b1, 7'($urandom)};
    imm = 8'($urandom);
    da = {1'b1, 7'($urandom)};
    pm[tgt] = {4'hc, 4'h0, imm};
    pm[tgt + 12'h001] = {4'ha, 4'h0, da};
    dq.push_back({1'b0, da, imm});
    wr(REG_PCL, {24'h0, tgt[7:0]}, RESP_OKAY);
    wait_pc(tgt);
    wait_pc(tgt + 12'h002);
    rd(REG_ACC, {RESP_OKAY, 24'h0, imm});
    repeat (8) @(posedge aclk);
    chk(34'(aq.size() + dq.size()), 34'h0);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    conclude();
  end
endmodule
